// ### bench/sdcac_dev_model.sv
// behavioural four-bank sdram device answering the controller's pins
`timescale 1ns/1ps
module sdcac_dev_model #(
    parameter int PAUSE = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command and address pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bs_lo,
    input wire logic bs_hi,
    input wire logic [11:0] addr,
    input wire logic [3:0] dqm,
    // data pins
    input wire logic [31:0] dq_wr,
    input wire logic dq_oe,
    output logic [31:0] dq_rd
);
    import sdcac_pkg::*;
    logic [31:0] mem [int];
    int rd_due [int];
    int act_at [4];
    logic [11:0] row_of [4];
    logic [11:0] mode;
    logic [3:0] open_b;
    logic [3:0] cmd;
    logic [1:0] bk;
    logic [1:0] wb;
    logic pre_seen, cke_q, acc;
    int errs, n_ref, cyc, nops, mrs_at, last_act, bl, t, wrem, wi, wc;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign bk = {bs_hi, bs_lo};

    // beat i wraps inside its burst
    function automatic int key(input int b, input int c, input int i);
        int cc;
        cc = mode[3] ? (c ^ i) : ((c & ~(bl - 1)) | ((c + i) & (bl - 1)));
        return (b << 20) | (int'(row_of[b]) << 8) | (cc & 255);
    endfunction

    task automatic wbeat();
        int k;
        k = key(wb, wc, wi);
        if (dq_oe !== 1'b1) errs++;
        if (!mem.exists(k)) mem[k] = 32'h0;
        for (int j = 0; j < 4; j++)
            if (!dqm[j]) mem[k][8*j+:8] = dq_wr[8*j+:8];
        wi++;
        wrem--;
    endtask

    initial begin
        errs = 0;
        mode = 12'h000;
        dq_rd = 32'h0;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc = 0;
            nops = 0;
            n_ref = 0;
            pre_seen = 0;
            cke_q = 0;
            open_b = 4'h0;
            wrem = 0;
            mrs_at = -99;
            last_act = -99;
            act_at = '{-99, -99, -99, -99};
            rd_due.delete();
        end else begin
            cyc++;
            bl = (mode[2:0] == 3'h7) ? 256 : (1 << mode[2:0]);
            t = cyc + int'(mode[6:4]) - 1;
            acc = (cmd == CMD_RD || cmd == CMD_WR);
            if (!pre_seen && cmd == CMD_NOP) begin
                nops++;
                if (nops <= PAUSE && (dqm !== 4'hf || cke !== 1'b1))
                    errs++;
            end else if (!pre_seen) begin
                if (cmd != CMD_PRE || nops < PAUSE || !addr[10]) errs++;
            end
            if (!cs_n && cmd != CMD_NOP && cyc - mrs_at < MODE_SET_CYCLE_DELAY_CYC) errs++;
            if (acc && (!open_b[bk] || cyc - act_at[bk] < TRCD_CYC))
                errs++;
            if (acc) wrem = 0;
            else if (wrem > 0) wbeat();
            // deselect codes match no item, so they are ignored
            case (cmd)
                CMD_PRE: begin
                    pre_seen = 1;
                    if (addr[10]) open_b = 4'h0;
                    else open_b[bk] = 1'b0;
                end
                CMD_REF: begin
                    if (open_b != 4'h0) errs++;
                    n_ref++;
                end
                CMD_MRS: begin
                    if (open_b != 4'h0 || !cke_q) errs++;
                    mode = addr;
                    mrs_at = cyc;
                end
                CMD_ACT: begin
                    if (n_ref < 8 || mrs_at < 0) errs++;
                    if (open_b[bk] || cyc - act_at[bk] < TRC_CYC)
                        errs++;
                    if (cyc - last_act < TRRD_CYC) errs++;
                    open_b[bk] = 1'b1;
                    act_at[bk] = cyc;
                    row_of[bk] = addr;
                    last_act = cyc;
                end
                CMD_RD: begin
                    for (int k = 0; k < 256; k++) rd_due.delete(t + k);
                    for (int i = 0; i < bl; i++)
                        rd_due[t + i] = key(bk, addr[7:0], i);
                end
                CMD_WR: begin
                    wb = bk;
                    wc = int'(addr[7:0]);
                    wi = 0;
                    wrem = bl;
                    wbeat();
                end
                default: ;
            endcase
            if (rd_due.exists(cyc)) begin
                if (dq_oe) errs++;
                dq_rd <= #1 mem.exists(rd_due[cyc]) ? mem[rd_due[cyc]] : 32'h0;
            end else begin
                // released bus must not look like held data
                dq_rd <= #1 ~dq_rd;
            end
            cke_q = cke;
        end
    end
endmodule

// ### bench/tb.sv
// testbench for the sdram controller against the device model
`timescale 1ns/1ps
module tb;
    import sdcac_pkg::*;
    localparam int PAUSE = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic wr_valid = 1'b0;
    logic [31:0] wr_data = 32'h0;
    sdcac_req_t req = '0;
    logic req_ack, init_done, wr_ready, rd_valid, dq_oe;
    logic cke, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi;
    logic [31:0] rd_data, dq_out, dq_in, dev_dq;
    logic [11:0] addr;
    logic [3:0] dqm;
    logic [31:0] got [4];
    int n0, acc;
    int miscompares = 0;
    int samples_checked = 0;

    always #2.5 clk = ~clk;
    // the wire carries whichever side has its driver on
    assign dq_in = dq_oe ? dq_out : dev_dq;

    sdcac_ctrl #(.PAUSE_CYC(PAUSE), .TRAS_MAX_CYC(20000)) dut_u (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ack(req_ack), .init_done(init_done), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .sdram_cke(cke), .sdram_cs_n(cs_n),
        .sdram_ras_n(ras_n), .sdram_cas_n(cas_n), .sdram_we_n(we_n),
        .bank_select_lo(bs_lo), .bank_select_hi(bs_hi), .sdram_addr(addr),
        .sdram_dqm(dqm), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
    );

    sdcac_dev_model #(.PAUSE(PAUSE)) dev_u (
        .clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bs_lo(bs_lo), .bs_hi(bs_hi),
        .addr(addr), .dqm(dqm), .dq_wr(dq_out), .dq_oe(dq_oe),
        .dq_rd(dev_dq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] word(input int i);
        return {16'ha5c3, 16'(i)};
    endfunction

    task automatic reset_and_init();
        int n;
        n = 0;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(dqm, 4'hf);
        check(cke, 1'b1);
        check(init_done, 1'b0);
        while (init_done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(init_done, 1'b1);
        @(negedge clk);
        check(dev_u.n_ref, 8);
        check(dev_u.mode, MODE_VALUE);
    endtask

    // offers n words back to back, counting those taken
    task automatic fill(input int n, input int base);
        acc = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            acc += int'(wr_ready);
            wr_valid = 1'b1;
            wr_data = word(base + i);
        end
        @(negedge clk);
        wr_valid = 1'b0;
    endtask

    task automatic access(input logic wr, input logic [1:0] b,
                          input logic [11:0] r, input logic [7:0] c);
        int n;
        int k;
        n = 0;
        k = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{write: wr, bank: b, row: r, col: c};
        while (req_ack !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'b0;
        check(req_ack, 1'b1);
        n = 0;
        while (!wr && k < 4 && n < 40) begin
            @(negedge clk);
            n++;
            if (rd_valid === 1'b1) begin
                got[k] = rd_data;
                k++;
            end
        end
        if (!wr) check(k, 4);
    endtask

    task automatic read_chk(input logic [1:0] b, input logic [11:0] r,
                            input logic [7:0] c, input int base, rot);
        access(1'b0, b, r, c);
        for (int i = 0; i < 4; i++)
            check(got[i], word(base + (i + rot) % 4));
    endtask

    initial begin
        reset_and_init();
        $display("test init finished");
        fill(17, 0);
        check(acc, 16);
        check(wr_ready, 1'b0);
        $display("test fifo fill finished");
        for (int b = 0; b < 4; b++)
            access(1'b1, 2'(b), 12'h555 * 12'(b), 8'hf0 + 8'(4 * b));
        // start two columns in, so the wrap is seen
        for (int b = 0; b < 4; b++)
            read_chk(2'(b), 12'h555 * 12'(b), 8'hf2 + 8'(4 * b),
                     4 * b, 2);
        check(wr_ready, 1'b1);
        $display("test four banks finished");
        fill(8, 32);
        access(1'b1, 2'h1, 12'h001, 8'h00);
        access(1'b1, 2'h1, 12'h002, 8'h00);
        read_chk(2'h1, 12'h001, 8'h00, 32, 0);
        read_chk(2'h1, 12'h002, 8'h00, 36, 0);
        $display("test row change finished");
        n0 = dev_u.n_ref;
        repeat (1700) @(negedge clk);
        check(dev_u.n_ref > n0, 1'b1);
        read_chk(2'h1, 12'h002, 8'h00, 36, 0);
        $display("test refresh finished");
        // reset lands in the middle of a write burst
        fill(4, 48);
        access(1'b1, 2'h2, 12'h010, 8'h40);
        repeat (5) @(negedge clk);
        reset_and_init();
        check(wr_ready, 1'b1);
        fill(4, 52);
        access(1'b1, 2'h2, 12'h010, 8'h40);
        read_chk(2'h2, 12'h010, 8'h40, 52, 0);
        check(dev_u.errs, 0);
        $display("test reset mid burst finished");
        end_sim();
    end

    // the tests need about 2300 cycles
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule

// ### rtl/sdcac_ctrl.sv
// close-page controller driving a four-bank 32-bit sdram over its pins
// Notes on behaviour
// R1 - wait the power-up pause with no-ops, then precharge all banks
// R2 - hold byte masks and clock enable high during the pause
// R3 - program the mode register once all banks are precharged
// R4 - issue eight auto refresh cycles during initialisation
// R5 - mode set only with banks precharged and clock enable high before
// R6 - device decodes all four strobes low as mode register set
// R7 - no command until the mode set cycle delay has passed
// R8 - activate first, wait row-to-column delay before read or write
// R9 - precharge before reactivating, same bank activates a row cycle apart
// R10 - activates to different banks spaced by the bank-to-bank delay
// R11 - never keep a bank open past the maximum row active time
// R12 - device treats row high, column low as column access
// R13 - new row in an open bank needs precharge then activate
// R14 - device takes a read or write on every cycle
// R15 - device decodes column low, row and write high as burst read
// R16 - device takes burst type and length from the mode register
// R17 - first write word goes out with the write command
// R18 - remaining write words follow on each edge to burst end
// R19 - device restarts a full burst when a read cuts a read
// R20 - mask read data in the first two cycles of a cutting write
// R21 - device restarts the burst when a write cuts a write
// R22 - release the data bus at least a cycle before read data
// R23 - device masks read bytes two cycles later, write bytes at once; sdcac_dev_model masks write bytes only
// R24 - device ignores commands while chip select is high
// R25 - twelve row bits, eight column bits, two bank select bits
// R26 - no-op whenever idle, and track which banks are open
// R27 - every delay counted in whole cycles from the clock period
`timescale 1ns/1ps
module sdcac_ctrl #(
    parameter int PAUSE_CYC = sdcac_pkg::PAUSE_DEF,
    parameter int TRAS_MAX_CYC = sdcac_pkg::TRAS_MAX_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access requests
    input wire logic req_valid,
    input wire sdcac_pkg::sdcac_req_t req,
    output logic req_ack,
    output logic init_done,
    // write data
    input wire logic wr_valid,
    input wire logic [31:0] wr_data,
    output logic wr_ready,
    // read data
    output logic rd_valid,
    output logic [31:0] rd_data,
    // sdram pins
    output logic sdram_cke,
    output logic sdram_cs_n,
    output logic sdram_ras_n,
    output logic sdram_cas_n,
    output logic sdram_we_n,
    output logic bank_select_lo,
    output logic bank_select_hi,
    output logic [11:0] sdram_addr,
    output logic [3:0] sdram_dqm,
    output logic [31:0] dq_out,
    output logic dq_oe,
    input wire logic [31:0] dq_in
);
    import sdcac_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [15:0] dec16(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    endfunction

    sdcac_state_t state;
    sdcac_state_t next_state;
    sdcac_req_t cur;
    logic [15:0] wait_cnt;
    logic [15:0] next_wait;
    logic [15:0] tras_cnt;
    logic [15:0] trc_cnt;
    logic [15:0] trrd_cnt;
    logic [15:0] refi_cnt;
    logic ref_due;
    logic [3:0] ref_cnt;
    logic [3:0] bank_open;
    logic [2:0] beat_left;
    logic beat_wr;
    logic [CAS_LAT:0] rd_sr;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic fifo_valid;
    logic [31:0] fifo_data;
    logic [4:0] fifo_level;
    logic fifo_pop;

    sdcac_fifo #(.WIDTH(32), .DEPTH(16)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wr_valid),
        .in_data(wr_data),
        .in_ready(wr_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

    wire wait_done = wait_cnt == 16'h0000;
    wire issue_pre_all = state == S_PRE_ALL && wait_done;
    wire issue_init_ref = state == S_INIT_REF && wait_done;
    wire issue_mode = state == S_MODE && wait_done;
    wire idle_ref = state == S_IDLE && wait_done && ref_due;
    wire fifo_enough = fifo_level >= 5'(BURST_LEN);
    wire act_ok = trc_cnt == 16'h0000 && trrd_cnt == 16'h0000;
    wire issue_act = state == S_IDLE && wait_done && !ref_due && req_valid
        && act_ok && (!req.write || fifo_enough);
    wire issue_rd = state == S_ACCESS && wait_done && !cur.write;
    wire issue_wr = state == S_ACCESS && wait_done && cur.write;
    wire issue_pre = state == S_PRE && wait_done && tras_cnt == 16'h0000;
    assign fifo_pop = issue_wr || (beat_wr && beat_left != 3'h0);
    wire rd_beat = issue_rd || (!beat_wr && beat_left != 3'h0);
    wire refi_hit = refi_cnt == 16'h0000;
    // idle cycles fall through to no-op
    wire [3:0] next_cmd = issue_act ? CMD_ACT : // R8 R26
        issue_rd ? CMD_RD :
        issue_wr ? CMD_WR :
        (issue_pre || issue_pre_all) ? CMD_PRE : // R13
        (issue_init_ref || idle_ref) ? CMD_REF : // R4
        issue_mode ? CMD_MRS : CMD_NOP; // R26
    wire [11:0] next_addr = issue_act ? req.row :
        (issue_rd || issue_wr) ? {4'h0, cur.col} :
        issue_pre_all ? ADDR_ALL_BANKS : // R1
        issue_mode ? MODE_VALUE : 12'h000;
    wire [1:0] next_bank = issue_act ? req.bank : cur.bank;

    assign sdram_cs_n = cmd[3];
    assign sdram_ras_n = cmd[2];
    assign sdram_cas_n = cmd[1];
    assign sdram_we_n = cmd[0];
    assign bank_select_lo = bank[0];
    assign bank_select_hi = bank[1];

    // every wait loads its count less one: next command lands n cycles on
    always_comb begin
        next_state = state;
        next_wait = dec16(wait_cnt); // R27
        unique case (state)
            S_PAUSE: begin
                if (wait_done) begin
                    next_state = S_PRE_ALL; // R1
                end
            end
            S_PRE_ALL: begin
                if (issue_pre_all) begin
                    next_state = S_INIT_REF; // R3
                    next_wait = TRP_CYC - 16'h0001;
                end
            end
            S_INIT_REF: begin
                if (issue_init_ref) begin
                    next_wait = TRFC_CYC - 16'h0001;
                    if (ref_cnt == 4'(INIT_REFRESHES - 1)) begin
                        next_state = S_MODE; // R4 R5
                    end
                end
            end
            S_MODE: begin
                if (issue_mode) begin
                    next_state = S_IDLE;
                    next_wait = MODE_SET_CYCLE_DELAY_CYC - 16'h0001; // R7
                end
            end
            S_IDLE: begin
                if (idle_ref) begin
                    next_wait = TRFC_CYC - 16'h0001;
                end else if (issue_act) begin
                    next_state = S_ACCESS;
                    next_wait = TRCD_CYC - 16'h0001; // R8
                end
            end
            S_ACCESS: begin
                if (issue_rd) begin
                    next_state = S_PRE;
                    next_wait = 16'(BURST_LEN - 1);
                end else if (issue_wr) begin
                    next_state = S_PRE;
                    next_wait = 16'(BURST_LEN - 1) + TWR_CYC;
                end
            end
            S_PRE: begin
                if (issue_pre) begin
                    next_state = S_IDLE; // R9 R11
                    next_wait = TRP_CYC - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_PAUSE;
            wait_cnt <= 16'(PAUSE_CYC - 1);
            ref_cnt <= 4'h0;
            cur <= '0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait;
            ref_cnt <= ref_cnt + 4'(issue_init_ref);
            cur <= issue_act ? req : cur;
        end
    end

    // one global row cycle timer: stricter than per bank, far fewer flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tras_cnt <= 16'h0000;
            trc_cnt <= 16'h0000;
            trrd_cnt <= 16'h0000;
        end else begin
            tras_cnt <= issue_act ? TRAS_MIN_CYC - 16'h0001 : dec16(tras_cnt);
            trc_cnt <= issue_act ? TRC_CYC - 16'h0001 : dec16(trc_cnt); // R9
            trrd_cnt <= issue_act ? TRRD_CYC - 16'h0001 : dec16(trrd_cnt); // R10
        end
    end

    // refresh request survives a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refi_cnt <= REFI_CYC - 16'h0001;
            ref_due <= 1'b0;
        end else begin
            refi_cnt <= refi_hit ? REFI_CYC - 16'h0001 : refi_cnt - 16'h0001;
            ref_due <= refi_hit || (ref_due && !idle_ref);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_open <= 4'h0;
        end else if (issue_pre_all) begin
            bank_open <= 4'h0;
        end else if (issue_pre) begin
            bank_open[cur.bank] <= 1'b0; // R26
        end else if (issue_act) begin
            bank_open[req.bank] <= 1'b1; // R26
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_left <= 3'h0;
            beat_wr <= 1'b0;
        end else if (issue_rd || issue_wr) begin
            beat_left <= 3'(BURST_LEN - 1); // R18
            beat_wr <= issue_wr;
        end else if (beat_left != 3'h0) begin
            beat_left <= beat_left - 3'h1;
        end
    end

    // pins: masks and clock enable high through the pause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= CMD_NOP;
            bank <= 2'h0;
            sdram_addr <= 12'h000;
            sdram_dqm <= 4'hf;
            sdram_cke <= 1'b1;
        end else begin
            cmd <= next_cmd;
            bank <= next_bank;
            sdram_addr <= next_addr;
            sdram_dqm <= {4{next_state == S_PAUSE}}; // R2
            sdram_cke <= 1'b1; // R2 R5
        end
    end

    // first word rides with the command; bus dropped before any read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= 32'h0000_0000;
            dq_oe <= 1'b0;
        end else begin
            dq_out <= fifo_pop ? fifo_data : dq_out; // R17 R18
            dq_oe <= fifo_pop; // R20 R22
        end
    end

    // capture point: one edge to the pins plus the cas latency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_sr <= '0;
            rd_valid <= 1'b0;
            rd_data <= 32'h0000_0000;
            req_ack <= 1'b0;
            init_done <= 1'b0;
        end else begin
            rd_sr <= {rd_sr[CAS_LAT-1:0], rd_beat};
            rd_valid <= rd_sr[CAS_LAT];
            rd_data <= rd_sr[CAS_LAT] ? dq_in : rd_data;
            req_ack <= issue_act;
            init_done <= init_done || issue_mode;
        end
    end

    // helper timing seen at the pins
    logic [15:0] since_act;
    logic [15:0] open_time;
    logic pre_all_seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_act <= 16'hffff;
            open_time <= 16'h0000;
            pre_all_seen <= 1'b0;
        end else begin
            since_act <= (cmd == CMD_ACT) ? 16'h0001 :
                (since_act == 16'hffff) ? since_act : since_act + 16'h0001;
            open_time <= (bank_open == 4'h0) ? 16'h0000 : open_time + 16'h0001;
            pre_all_seen <= pre_all_seen || issue_pre_all;
        end
    end

    pause_nop_a: assert property ( // R1
        state == S_PAUSE |-> cmd == CMD_NOP)
        else $error("command issued during power-up pause");
    pause_mask_a: assert property ( // R2
        state == S_PAUSE && $past(state == S_PAUSE)
        |-> sdram_dqm == 4'hf && sdram_cke)
        else $error("mask or clock enable low during pause");
    mode_order_a: assert property ( // R3
        cmd == CMD_MRS |-> pre_all_seen && bank_open == 4'h0)
        else $error("mode set before all banks precharged");
    init_refs_a: assert property ( // R4
        $rose(init_done) |-> ref_cnt == 4'(INIT_REFRESHES))
        else $error("wrong number of initial refreshes");
    mode_cke_a: assert property ( // R5
        cmd == CMD_MRS |-> sdram_cke && $past(sdram_cke))
        else $error("clock enable not high before mode set");
    mode_gap_a: assert property ( // R7
        cmd == CMD_MRS |=> (cmd == CMD_NOP) [*2])
        else $error("command inside mode set delay");
    act_to_col_a: assert property ( // R8
        cmd == CMD_RD || cmd == CMD_WR |-> since_act >= TRCD_CYC)
        else $error("column access too soon after activate");
    act_cycle_a: assert property ( // R9
        cmd == CMD_ACT |-> since_act >= TRC_CYC)
        else $error("activates closer than row cycle time");
    act_banks_a: assert property ( // R10
        cmd == CMD_ACT |-> since_act >= TRRD_CYC)
        else $error("activates closer than bank delay");
    open_limit_a: assert property ( // R11
        open_time < 16'(TRAS_MAX_CYC))
        else $error("bank held open too long");
    reopen_a: assert property ( // R13
        issue_act |-> bank_open == 4'h0)
        else $error("activate into an open bank");
    wr_first_a: assert property ( // R17
        cmd == CMD_WR |-> dq_oe && sdram_dqm == 4'h0)
        else $error("first write word not with command");
    wr_rest_a: assert property ( // R18
        cmd == CMD_WR |=> dq_oe [*3] ##1 !dq_oe)
        else $error("write burst words not on each edge");
    rd_release_a: assert property ( // R22
        cmd == CMD_RD |-> !dq_oe ##1 !dq_oe)
        else $error("data bus driven around a read");
    pop_data_a: assert property (fifo_pop |-> fifo_valid) // R18
        else $error("write word popped from empty fifo");

    init_seen_c: cover property ($rose(init_done));
    write_seen_c: cover property (cmd == CMD_WR ##[1:40] cmd == CMD_PRE);
    read_seen_c: cover property (cmd == CMD_RD ##4 rd_valid [*4]);
    refresh_seen_c: cover property (init_done && cmd == CMD_REF);
endmodule

// ### rtl/sdcac_fifo.sv
// write data fifo with registered full and empty flags
`timescale 1ns/1ps
module sdcac_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] next_level = level + (AW+1)'(push) - (AW+1)'(pop);

    assign out_data = mem[rp];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // flags from the next level so both stay registered and honest
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp <= wp + AW'(push);
            rp <= rp + AW'(pop);
            level <= next_level;
            in_ready <= next_level != (AW+1)'(DEPTH);
            out_valid <= next_level != '0;
        end
    end
endmodule

// ### rtl/sdcac_pkg.sv
// constants, pin codes, request carrier and states of the sdram controller
package sdcac_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BURST_LEN = 4;
    localparam int CAS_LAT = 3;
    localparam int INIT_REFRESHES = 8;
    localparam int PAUSE_US = 200;
    localparam int TRCD_NS = 18;
    localparam int TRP_NS = 18;
    localparam int TRC_NS = 60;
    localparam int TRRD_NS = 12;
    localparam int TRFC_NS = 60;
    localparam int MODE_SET_CYCLE_DELAY_NS = 12;
    localparam int TWR_NS = 12;
    localparam int TRAS_MIN_NS = 42;
    localparam int TRAS_MAX_NS = 100000;
    localparam int REFI_NS = 7800;

    // least times round up, never below one cycle
    function automatic int ns_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [15:0] TRCD_CYC = 16'(ns_up(TRCD_NS));
    localparam logic [15:0] TRP_CYC = 16'(ns_up(TRP_NS));
    localparam logic [15:0] TRC_CYC = 16'(ns_up(TRC_NS));
    localparam logic [15:0] TRRD_CYC = 16'(ns_up(TRRD_NS));
    localparam logic [15:0] TRFC_CYC = 16'(ns_up(TRFC_NS));
    localparam logic [15:0] MODE_SET_CYCLE_DELAY_CYC = 16'(ns_up(MODE_SET_CYCLE_DELAY_NS));
    localparam logic [15:0] TWR_CYC = 16'(ns_up(TWR_NS));
    localparam logic [15:0] TRAS_MIN_CYC = 16'(ns_up(TRAS_MIN_NS));
    // longest times round down
    localparam logic [15:0] REFI_CYC = 16'(REFI_NS * CLK_MHZ / 1000);
    localparam int TRAS_MAX_DEF = TRAS_MAX_NS * CLK_MHZ / 1000;
    localparam int PAUSE_DEF = PAUSE_US * CLK_MHZ;

    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [11:0] ADDR_ALL_BANKS = 12'h400;
    // mode word: burst of four, sequential, latency three
    localparam logic [11:0] MODE_VALUE = 12'h032;

    typedef struct packed {
        logic write;
        logic [1:0] bank;
        logic [11:0] row;
        logic [7:0] col;
    } sdcac_req_t;

    typedef enum logic [6:0] {
        S_PAUSE = 7'h01,
        S_PRE_ALL = 7'h02,
        S_INIT_REF = 7'h04,
        S_MODE = 7'h08,
        S_IDLE = 7'h10,
        S_ACCESS = 7'h20,
        S_PRE = 7'h40
    } sdcac_state_t;
endpackage
